// File: rtl/rcc_map.vh
// register map, field positions, reset values and timebase counts of the rtc calibration block
`ifndef RCC_MAP_VH
`define RCC_MAP_VH

// register indices; byte address is four times the index
`define RCC_IDX_DAY 4'h5
`define RCC_IDX_DATE 4'h6
`define RCC_IDX_MONTH 4'h7
`define RCC_IDX_YEAR 4'h8
`define RCC_IDX_CAL 4'hF

// calibration_output_config fields
`define RCC_CAL_DEEP_BIT 7
`define RCC_CAL_EN_BIT 6
`define RCC_CAL_CAL_FREQ_SELECT_HI 5
`define RCC_CAL_CAL_FREQ_SELECT_LO 4
`define RCC_CAL_ROUTE_HI 3

// reset values
`define RCC_CAL_RST 8'h00
`define RCC_DAY_RST 8'h00
`define RCC_DATE_RST 8'h01
`define RCC_MONTH_RST 8'h01
`define RCC_YEAR_RST 8'h00

// calendar limits
`define RCC_DAY_LAST 8'h06
`define RCC_MONTH_LAST 8'h0C
`define RCC_LEAP_YEAR_MAX 8'h60

// frequency select codes
`define RCC_CAL_FREQ_SELECT_1HZ 2'h0
`define RCC_CAL_FREQ_SELECT_512HZ 2'h1
`define RCC_CAL_FREQ_SELECT_500HZ 2'h2
`define RCC_CAL_FREQ_SELECT_16KHZ 2'h3

// half periods in timebase ticks: normal modes count 32.768 kHz ticks,
// fast modes count the 125x timebase (4.096 MHz) ticks
`define RCC_HALF_1HZ 14'h4000
`define RCC_HALF_512HZ 14'h0020
`define RCC_HALF_500HZ 14'h1000
`define RCC_HALF_16KHZ 14'h0080

`endif

// File: rtl/rcc_top.v
// rtc calibration pulse routing and calendar date/month/year rollover
//
// Overview of operation
// - In the lowest power state with deep-sleep and enable set, only pin a gets the pulse, and only with route bit 0 set.
// - With enable clear no pin has the pulse; with it set each route-selected pin has it outside the lowest power state.
// - Frequency select 00/01/10/11 gives 1 Hz, 512 Hz, 500 Hz and 16 kHz.
// - With the enable set, route bit 3 drives pin d and route bit 2 drives pin c.
// - With the enable set, route bit 1 drives pin b and route bit 0 drives pin a.
// - The month length used for date rollover follows the month counter and leap years.
// - Months 1,3,5,7,8,10,12 roll over after day 31 and months 4,6,9,11 after day 30.
// - Passing the last day wraps the date to 1 and increments the month; the date resets to 1.
// - The month wraps from 12 to 1 and increments the year; the month resets to 1.
// - An hour wrap from 23 to 0 advances the day of week and the date, then rollover applies.
`include "rcc_map.vh"

module rcc_top (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // compensated timebase and rtc events, same clock domain
    input wire tick_norm_i,
    input wire tick_fast_i,
    input wire hour_wrap_i,
    input wire lowest_power_state_i,
    // pins: index 3..0 = d (port2 bit3), c (port1 bit2), b (port0 bit7), a (port0 bit5)
    input wire [3:0] port_dout_i,
    output reg [3:0] pin_o
);

    reg [7:0] cal_cfg_r;
    reg [7:0] day_r;
    reg [7:0] date_r;
    reg [7:0] month_r;
    reg [7:0] year_r;
    reg [13:0] div_cnt_r;
    reg cal_pulse_r;

    // bus decode; ack is registered, so each access costs one wait state and the
    // master may hold cyc between accesses, since the ack cycle takes no request
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [5:0] reg_idx = wb_adr_i[7:2];
    wire wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
    wire wr_cal = wr_lane0 && (reg_idx == {2'h0, `RCC_IDX_CAL});
    wire wr_day = wr_lane0 && (reg_idx == {2'h0, `RCC_IDX_DAY});
    wire wr_date = wr_lane0 && (reg_idx == {2'h0, `RCC_IDX_DATE});
    wire wr_month = wr_lane0 && (reg_idx == {2'h0, `RCC_IDX_MONTH});
    wire wr_year = wr_lane0 && (reg_idx == {2'h0, `RCC_IDX_YEAR});

    wire cal_en = cal_cfg_r[`RCC_CAL_EN_BIT];
    wire cal_deep = cal_cfg_r[`RCC_CAL_DEEP_BIT];
    wire [1:0] cal_freq_select = cal_cfg_r[`RCC_CAL_CAL_FREQ_SELECT_HI:`RCC_CAL_CAL_FREQ_SELECT_LO];

    // read mux and ack; unmapped words read as zero and are still acknowledged
    // so a probe of a spare address never stalls the bus
    reg [7:0] rd_byte;
    always @* begin
        if (reg_idx == {2'h0, `RCC_IDX_CAL}) begin
            rd_byte = cal_cfg_r;
        end else if (reg_idx == {2'h0, `RCC_IDX_DAY}) begin
            rd_byte = day_r;
        end else if (reg_idx == {2'h0, `RCC_IDX_DATE}) begin
            rd_byte = date_r;
        end else if (reg_idx == {2'h0, `RCC_IDX_MONTH}) begin
            rd_byte = month_r;
        end else if (reg_idx == {2'h0, `RCC_IDX_YEAR}) begin
            rd_byte = year_r;
        end else begin
            rd_byte = 8'h00;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= {24'h000000, rd_byte};
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            cal_cfg_r <= `RCC_CAL_RST;
        end else if (wr_cal) begin
            cal_cfg_r <= wb_dat_i[7:0];
        end
    end

    // month length; year 0 is taken as not leap
    // a year past 96 counts as common, the leap table stops there
    wire leap = (year_r[1:0] == 2'h0) && (year_r != 8'h00)
        && (year_r <= `RCC_LEAP_YEAR_MAX);
    reg [7:0] last_day;
    always @* begin
        case (month_r)
            8'h04, 8'h06, 8'h09, 8'h0B: last_day = 8'h1E;
            8'h02: last_day = leap ? 8'h1D : 8'h1C;
            default: last_day = 8'h1F;
        endcase
    end

    // calendar; a software write to a counter wins over a same-cycle day advance
    // the compare is >=, so an out-of-range date written by software still rolls
    // over at the next day instead of counting on past the month end
    wire date_roll = hour_wrap_i && (date_r >= last_day);
    wire month_roll = date_roll && (month_r >= `RCC_MONTH_LAST);
    always @(posedge clk_i) begin
        if (rst_i) begin
            day_r <= `RCC_DAY_RST;
            date_r <= `RCC_DATE_RST;
            month_r <= `RCC_MONTH_RST;
            year_r <= `RCC_YEAR_RST;
        end else begin
            if (wr_day) begin
                day_r <= wb_dat_i[7:0];
            end else if (hour_wrap_i) begin
                day_r <= (day_r >= `RCC_DAY_LAST) ? 8'h00 : day_r + 8'h01;
            end
            if (wr_date) begin
                date_r <= wb_dat_i[7:0];
            end else if (date_roll) begin
                date_r <= 8'h01;
            end else if (hour_wrap_i) begin
                date_r <= date_r + 8'h01;
            end
            if (wr_month) begin
                month_r <= wb_dat_i[7:0];
            end else if (month_roll) begin
                month_r <= 8'h01;
            end else if (date_roll) begin
                month_r <= month_r + 8'h01;
            end
            if (wr_year) begin
                year_r <= wb_dat_i[7:0];
            end else if (month_roll) begin
                year_r <= year_r + 8'h01;
            end
        end
    end

    // pulse divider; counts only compensated ticks so added or dropped
    // timebase pulses shift the output edges
    reg [13:0] half_cnt;
    reg div_tick;
    always @* begin
        case (cal_freq_select)
            `RCC_CAL_FREQ_SELECT_1HZ: half_cnt = `RCC_HALF_1HZ;
            `RCC_CAL_FREQ_SELECT_512HZ: half_cnt = `RCC_HALF_512HZ;
            `RCC_CAL_FREQ_SELECT_500HZ: half_cnt = `RCC_HALF_500HZ;
            default: half_cnt = `RCC_HALF_16KHZ;
        endcase
        div_tick = cal_freq_select[1] ? tick_fast_i : tick_norm_i;
    end

    reg [1:0] cal_freq_select_q_r;
    wire cal_freq_select_chg = (cal_freq_select_q_r != cal_freq_select);
    wire div_last = (div_cnt_r >= half_cnt - 14'h0001);
    always @(posedge clk_i) begin
        if (rst_i) begin
            cal_freq_select_q_r <= 2'h0;
            div_cnt_r <= 14'h0000;
            cal_pulse_r <= 1'b0;
        end else begin
            cal_freq_select_q_r <= cal_freq_select;
            // a mode change restarts the divider and drops the pulse low, so the first edge after it
            // comes a whole half period later; a high phase already under way is cut short
            if (cal_freq_select_chg || !cal_en) begin
                div_cnt_r <= 14'h0000;
                cal_pulse_r <= 1'b0;
            end else if (div_tick) begin
                if (div_last) begin
                    div_cnt_r <= 14'h0000;
                    cal_pulse_r <= ~cal_pulse_r;
                end else begin
                    div_cnt_r <= div_cnt_r + 14'h0001;
                end
            end
        end
    end

    // pin routing; pulse and port value both pass one flip-flop, so changing a
    // route bit never leaves a combinational path to a pin
    wire [3:0] pin_sel;
    wire [3:0] pin_nxt;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pin
            if (g == 0) begin : g_deep
                // in the lowest power state only pin a may carry the pulse
                assign pin_sel[g] = cal_en && cal_cfg_r[g]
                    && (!lowest_power_state_i || cal_deep);
            end else begin : g_main
                assign pin_sel[g] = cal_en && cal_cfg_r[g]
                    && !lowest_power_state_i;
            end
            // an unselected pin keeps its ordinary port value
            assign pin_nxt[g] = pin_sel[g] ? cal_pulse_r : port_dout_i[g];
        end
    endgenerate

    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= 4'h0;
        end else begin
            pin_o <= pin_nxt;
        end
    end

endmodule

// File: verification/rcc_freq_meter.sv
// frequency counter model: cycles between rising edges of one pin
module rcc_freq_meter (
    input wire clk_i,
    input wire sig_i,
    output logic [31:0] period_o = 32'h0,
    output logic [7:0] rises_o = 8'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt_r = 32'h0;
    logic last_r = 1'b0;
    always @(posedge clk_i) begin
        last_r <= sig_i;
        cnt_r <= (sig_i && !last_r) ? 32'h0 : cnt_r + 32'h1;
        if (sig_i && !last_r) begin
            period_o <= cnt_r + 32'h1;
            rises_o <= rises_o + 8'h1;
        end
    end
endmodule

// File: verification/rcc_top_asserts.sv
// port checker for the rtc calibration block
module rcc_top_asserts (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire lowest_power_state_i,
    input wire [3:0] port_dout_i,
    input wire [3:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cfg_r;
    logic [3:0] mask_w;
    wire req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // shadow of the config so pin checks need no view inside
    always @(posedge clk_i) begin
        if (rst_i)
            cfg_r <= 8'h00;
        else if (req_w && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h0F)
            cfg_r <= wb_dat_i[7:0];
    end
    assign mask_w = lowest_power_state_i ? {3'h0, &{cfg_r[7:6], cfg_r[0]}} :
        (cfg_r[6] ? cfg_r[3:0] : 4'h0);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_ONE: assert property (req_w |=> wb_ack_o) else $error("ack missing");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack unasked");
    AST_RD_HI: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
        else $error("read high bits set");
    AST_PIN_PORT: assert property (!$past(rst_i) |->
        (pin_o & ~$past(mask_w)) == ($past(port_dout_i) & ~$past(mask_w)))
        else $error("unselected pin lost port value");
    AST_PIN_SAME: assert property ($past(mask_w) == 4'hF |->
        pin_o inside {4'h0, 4'hF}) else $error("routed pins differ");
    AST_DEEP: assert property (lowest_power_state_i && cfg_r[7:6] == 2'h3 |=>
        pin_o[3:1] == $past(port_dout_i[3:1])) else $error("pulse on pin other than a");
    AST_RST: assert property ($fell(rst_i) |-> pin_o == 4'h0 && !wb_ack_o && wb_dat_o == 32'h0)
        else $error("reset state wrong");
endmodule

bind rcc_top rcc_top_asserts i_rcc_top_asserts (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .lowest_power_state_i,
    .port_dout_i, .pin_o);

// File: verification/test_rcc_top.sv
// self-checking testbench for the rtc calibration block
module test_rcc_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, hw = 1'b0, lps = 1'b0;
    logic tick = 1'b1, slow = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] dout = 4'h5;
    wire [31:0] rdat, period;
    wire ack;
    wire [3:0] pin;
    wire [7:0] rises;
    int num_errors = 0, samples_checked = 0;
    always #2 clk_i = ~clk_i;
    // ticks high every cycle make periods exact; slow mode drops every other tick
    // as the compensation would, and the pulse period must stretch with it
    always @(posedge clk_i) tick <= slow ? ~tick : 1'b1;
    rcc_top i_rcc_top (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tick_norm_i(tick), .tick_fast_i(tick), .hour_wrap_i(hw),
        .lowest_power_state_i(lps), .port_dout_i(dout), .pin_o(pin));
    rcc_freq_meter i_rcc_freq_meter (.clk_i, .sig_i(pin[0]), .period_o(period),
        .rises_o(rises));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        {cyc, we, adr, wdat} <= {1'b1, w, a, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            num_errors++;
            stop_test();
        end
        q = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, {24'h0, d}, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        check(q, {24'h0, e});
    endtask
    // the first rise after a change is partial, so callers wait for two
    task automatic waitr(input logic [7:0] k);
        logic [7:0] r;
        r = rises + k;
        for (int i = 0; i < 60000 && rises !== r; i++) @(posedge clk_i);
        if (rises !== r) begin
            num_errors++;
            stop_test();
        end
    endtask
    task automatic t_reset;
        rd(8'h3C, 8'h00);
        rd(8'h18, 8'h01);
        rd(8'h1C, 8'h01);
        rd(8'h14, 8'h00);
        rd(8'h20, 8'h00);
        rd(8'h40, 8'h00);
        check(32'(pin), 32'h5);
        $display("done reset");
    endtask
    task automatic t_freq;
        logic [31:0] half [4] = '{32'd16384, 32'd32, 32'd4096, 32'd128};
        for (logic [2:0] f = 0; f < 4; f++) begin
            wr(8'h3C, {2'h1, f[1:0], 4'hF});
            rd(8'h3C, {2'h1, f[1:0], 4'hF});
            waitr(8'h2);
            check(period, 2 * half[f]);
        end
        $display("done freq");
    endtask
    task automatic t_comp;
        slow <= 1'b1;
        wr(8'h3C, 8'h51);
        rd(8'h3C, 8'h51);
        waitr(8'h2);
        check(period, 32'd128);
        slow <= 1'b0;
        $display("done compensation");
    endtask
    task automatic t_deep;
        logic [31:0] hi = 32'h0;
        logic [31:0] bad = 32'h0;
        dout <= 4'hA;
        lps <= 1'b1;
        wr(8'h3C, 8'hDF);
        rd(8'h3C, 8'hDF);
        waitr(8'h2);
        check(period, 32'd64);
        check(32'(pin[3:1]), 32'h5);
        wr(8'h3C, 8'h5F);
        check(32'(pin), 32'hA);
        lps <= 1'b0;
        wr(8'h3C, 8'h1F);
        check(32'(pin), 32'hA);
        // routes d and b only: both carry the same pulse, c and a keep the port value
        wr(8'h3C, 8'h5A);
        repeat (64) @(posedge clk_i);
        for (int i = 0; i < 64; i++) begin
            @(posedge clk_i);
            hi += pin[3];
            if (pin[1] !== pin[3] || pin[2] !== dout[2] || pin[0] !== dout[0])
                bad++;
        end
        check(hi, 32'd32);
        check(bad, 32'h0);
        $display("done deep");
    endtask
    task automatic t_cal;
        logic [47:0] t [12] = '{48'h02041C1D0204, 48'h02041D010304, 48'h02001C010300,
            48'h02601C1D0260, 48'h04051E010505, 48'h04051D1E0405, 48'h01051F010205,
            48'h0C071F010108, 48'h0B071E010C07, 48'h02641C010364, 48'h0A051E1F0A05,
            48'h09051E010A05};
        for (int i = 0; i < 12; i++) begin
            wr(8'h20, t[i][39:32]);
            wr(8'h1C, t[i][47:40]);
            wr(8'h18, t[i][31:24]);
            hw <= 1'b1;
            @(posedge clk_i);
            hw <= 1'b0;
            @(posedge clk_i);
            rd(8'h18, t[i][23:16]);
            rd(8'h1C, t[i][15:8]);
            rd(8'h20, t[i][7:0]);
        end
        rd(8'h14, 8'h05);
        $display("done calendar");
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_freq();
        t_comp();
        t_deep();
        t_cal();
        stop_test();
    end
endmodule
